// ==== sdip_top.v ====
// Functional notes
// - eight separately latched 8-bit channel registers, one per analog output.
// - each channel register takes any unsigned code from 0 to 255.
// - select falling restarts the serial logic for a fresh 16-bit word.
// - while select is low, data is sampled on each serial clock rising edge.
// - select rising captures the 16-bit word; later clock edges ignored until next frame.
// - serial writes reach the channel registers only when the frame closes.
// - at frame end the word goes to channels or buffer config by its contents.
// - one frame may update any subset of channels, none up to all eight.
// - each output pair selects unbuffered or buffered; half or full buffering is set per group of four channels.
// - shifted bits appear on an open-drain serial output for chaining.
// - power-down input high runs normally; low enters shutdown.
// - frame is 8-bit pointer then 8-bit data, msb first, data lsb last.
// - channels with pointer bit set get the data; others and buffers unchanged.
// - zero pointer with config flag set loads buffer modes from data bits 5..0.
// - all-zero frame is a filler word that changes nothing.
`include "sdip_defines.vh"
module sdip_top #(
	parameter CHANNELS   = 8,
	parameter CODE_W     = 8,
	parameter FRAME_BITS = `SDIP_FRAME_BITS,
	parameter FIFO_DEPTH = 8,
	parameter FIFO_AW    = 3
) (
	input  wire                       clk,
	input  wire                       rst,
	input  wire                       ser_clk,
	input  wire                       frame_sel_n,
	input  wire                       ser_din,
	input  wire                       power_down_n,
	output reg                        ser_dout_o,
	output reg                        ser_dout_oe,
	output reg  [CHANNELS*CODE_W-1:0] chan_codes,
	output reg  [CHANNELS*2-1:0]      chan_modes,
	output reg                        shutdown,
	input  wire [3:0]                 avs_address,
	input  wire                       avs_read,
	input  wire                       avs_write,
	input  wire [31:0]                avs_writedata,
	output reg  [31:0]                avs_readdata,
	output reg                        avs_waitrequest
);
	localparam ST_IDLE  = 1'b0;
	localparam ST_SHIFT = 1'b1;

	// pin synchronisers
	reg [1:0] sclk_sync_r;
	reg [1:0] sel_sync_r;
	reg [1:0] din_sync_r;
	reg [1:0] pd_sync_r;
	reg       sclk_prev_r;
	reg       sel_prev_r;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sclk_sync_r <= 2'h0;
			sel_sync_r  <= 2'h3;
			din_sync_r  <= 2'h0;
			pd_sync_r   <= 2'h3;
			sclk_prev_r <= 1'b0;
			sel_prev_r  <= 1'b1;
		end else begin
			sclk_sync_r <= {sclk_sync_r[0], ser_clk};
			sel_sync_r  <= {sel_sync_r[0], frame_sel_n};
			din_sync_r  <= {din_sync_r[0], ser_din};
			pd_sync_r   <= {pd_sync_r[0], power_down_n};
			sclk_prev_r <= sclk_sync_r[1];
			sel_prev_r  <= sel_sync_r[1];
		end
	end

	wire sclk_rise = sclk_sync_r[1] & ~sclk_prev_r;
	wire sel_fall  = ~sel_sync_r[1] & sel_prev_r;
	wire sel_rise  = sel_sync_r[1] & ~sel_prev_r;

	// serial shifter
	reg                  state_r;
	reg [FRAME_BITS-1:0] shreg_r;
	reg [4:0]            bitcnt_r;
	reg                  ovf_r;
	wire                 fifo_in_ready;
	wire                 cap_valid = sel_rise & (state_r == ST_SHIFT);
	wire                 ctl_clr_ovf;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r  <= ST_IDLE;
			shreg_r  <= {FRAME_BITS{1'b0}};
			bitcnt_r <= 5'h0;
			ovf_r    <= 1'b0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (sel_fall) begin
						state_r  <= ST_SHIFT;
						bitcnt_r <= 5'h0;
					end
				end
				ST_SHIFT: begin
					if (sel_rise)
						state_r <= ST_IDLE;
					else if (sclk_rise) begin
						shreg_r  <= {shreg_r[FRAME_BITS-2:0], din_sync_r[1]};
						bitcnt_r <= (bitcnt_r == 5'h1f) ? bitcnt_r : bitcnt_r + 5'h1;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
			// lost frame flag: set wins over clear
			if (cap_valid & ~fifo_in_ready)
				ovf_r <= 1'b1;
			else if (ctl_clr_ovf)
				ovf_r <= 1'b0;
		end
	end

	// open-drain chain output: drive low only
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ser_dout_o  <= 1'b0;
			ser_dout_oe <= 1'b0;
		end else begin
			ser_dout_o  <= 1'b0;
			ser_dout_oe <= ~shreg_r[FRAME_BITS-1];
		end
	end

	// captured frames queue
	wire                  fifo_out_valid;
	wire [FRAME_BITS-1:0] fifo_out_data;
	wire                  apply_ready = 1'b1;

	sdip_fifo #(
		.WIDTH (FRAME_BITS),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (cap_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (shreg_r),
		.out_valid (fifo_out_valid),
		.out_ready (apply_ready),
		.out_data  (fifo_out_data)
	);

	// frame apply
	wire [7:0] ptr  = fifo_out_data[`SDIP_PTR_MSB:`SDIP_PTR_LSB];
	wire [7:0] dat  = fifo_out_data[`SDIP_DAT_MSB:`SDIP_DAT_LSB];
	wire       cfgw = (ptr == 8'h00) & dat[`SDIP_CFG_FLAG_BIT];

	function [1:0] mode_of;
		input en;
		input full;
		begin
			if (!en)
				mode_of = `SDIP_MODE_UNBUF;
			else if (full)
				mode_of = `SDIP_MODE_FULL;
			else
				mode_of = `SDIP_MODE_HALF;
		end
	endfunction

	wire [1:0] m01 = mode_of(dat[`SDIP_CFG_EN01_BIT], dat[`SDIP_CFG_FULL03_BIT]);
	wire [1:0] m23 = mode_of(dat[`SDIP_CFG_EN23_BIT], dat[`SDIP_CFG_FULL03_BIT]);
	wire [1:0] m45 = mode_of(dat[`SDIP_CFG_EN45_BIT], dat[`SDIP_CFG_FULL47_BIT]);
	wire [1:0] m67 = mode_of(dat[`SDIP_CFG_EN67_BIT], dat[`SDIP_CFG_FULL47_BIT]);

	// software write port into channels
	// writes land on the edge that sees waitrequest low, unless a queued frame is applied on that edge; then the write is lost
	wire sw_chan_wr = avs_write & ~avs_waitrequest & (avs_address < `SDIP_REG_MODES);
	wire sw_ctrl_wr = avs_write & ~avs_waitrequest & (avs_address == `SDIP_REG_CTRL);
	assign ctl_clr_ovf = sw_ctrl_wr & avs_writedata[`SDIP_ST_OVF_BIT];

	integer i;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			chan_codes <= {CHANNELS{`SDIP_CHAN_RST}};
			chan_modes <= {CHANNELS{`SDIP_MODE_RST}};
		end else if (fifo_out_valid) begin
			if (cfgw) begin
				chan_modes <= {m67, m67, m45, m45, m23, m23, m01, m01};
			end else begin
				for (i = 0; i < CHANNELS; i = i + 1) begin
					if (ptr[i])
						chan_codes[i*CODE_W +: CODE_W] <= dat;
				end
			end
		end else if (sw_chan_wr) begin
			chan_codes[avs_address[2:0]*CODE_W +: CODE_W] <= avs_writedata[7:0];
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst)
			shutdown <= 1'b0;
		else
			shutdown <= ~pd_sync_r[1];
	end

	// avalon slave: one wait state per access
	wire [4:0] status = {ovf_r, state_r, shutdown, ~fifo_in_ready, ~fifo_out_valid};

	function [31:0] rd_mux;
		input [3:0]                   a;
		input [CHANNELS*CODE_W-1:0]   c;
		input [CHANNELS*2-1:0]        m;
		input [4:0]                   s;
		begin
			if (a < `SDIP_REG_MODES)
				rd_mux = {24'h000000, c[a[2:0]*CODE_W +: CODE_W]};
			else if (a == `SDIP_REG_MODES)
				rd_mux = {16'h0000, m};
			else if (a == `SDIP_REG_STATUS)
				rd_mux = {27'h0000000, s};
			else
				rd_mux = 32'h00000000;
		end
	endfunction

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end else begin
			if ((avs_read | avs_write) & avs_waitrequest) begin
				avs_waitrequest <= 1'b0;
				avs_readdata    <= avs_read ? rd_mux(avs_address, chan_codes, chan_modes, status)
				                            : 32'h00000000;
			end else
				avs_waitrequest <= 1'b1;
		end
	end
endmodule // sdip_top

// ==== sdip_defines.vh ====
`ifndef SDIP_DEFINES_VH
`define SDIP_DEFINES_VH
// frame layout
`define SDIP_FRAME_BITS     16
`define SDIP_PTR_MSB        15
`define SDIP_PTR_LSB        8
`define SDIP_DAT_MSB        7
`define SDIP_DAT_LSB        0
// buffer mode word fields
`define SDIP_CFG_FLAG_BIT   7
`define SDIP_CFG_EN01_BIT   5
`define SDIP_CFG_EN23_BIT   4
`define SDIP_CFG_FULL03_BIT 3
`define SDIP_CFG_EN45_BIT   2
`define SDIP_CFG_EN67_BIT   1
`define SDIP_CFG_FULL47_BIT 0
// buffer mode encodings
`define SDIP_MODE_UNBUF     2'h0
`define SDIP_MODE_HALF      2'h1
`define SDIP_MODE_FULL      2'h2
// reset values
`define SDIP_CHAN_RST       8'h00
`define SDIP_MODE_RST       2'h0
// register map, word addresses
`define SDIP_REG_CHAN0      4'h0
`define SDIP_REG_MODES      4'h8
`define SDIP_REG_STATUS     4'h9
`define SDIP_REG_CTRL       4'ha
`define SDIP_REG_LAST       4'hb
// status bits
`define SDIP_ST_EMPTY_BIT   0
`define SDIP_ST_FULL_BIT    1
`define SDIP_ST_PD_BIT      2
`define SDIP_ST_ACT_BIT     3
`define SDIP_ST_OVF_BIT     4
`endif

// ==== sdip_fifo.v ====
module sdip_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             clk,
	input  wire             rst,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wp_r;
	reg [AW-1:0]    rp_r;
	reg [AW:0]      cnt_r;
	wire            push;
	wire            pop;

	assign in_ready  = (cnt_r != DEPTH[AW:0]);
	assign out_valid = (cnt_r != {(AW+1){1'b0}});
	assign out_data  = mem[rp_r];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always @(posedge clk) begin
		if (push)
			mem[wp_r] <= in_data;
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_r  <= {AW{1'b0}};
			rp_r  <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
			if (pop)
				rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
			if (push & ~pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop & ~push)
				cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule // sdip_fifo

// ==== sdip_host.sv ====
module sdip_host(
	output logic ser_clk,
	output logic frame_sel_n,
	output logic ser_din,
	input  wire  dout_wire
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] got;
	initial begin
		ser_clk = 0;
		frame_sel_n = 1;
		ser_din = 0;
		got = 0;
	end
	// one frame, clock idles low outside it
	task automatic send(input logic [15:0] w);
		frame_sel_n = 0;
		#80;
		for (int i = 15; i >= 0; i--) begin
			ser_din = w[i];
			#80;
			got = {got[14:0], dout_wire};
			ser_clk = 1;
			#80;
			ser_clk = 0;
		end
		#80 frame_sel_n = 1;
		ser_din = ~ser_din;
		#400;
	endtask
endmodule // sdip_host

// ==== sdip_top_monitor.sv ====
module sdip_top_monitor(
	input logic clk, rst, ser_clk, frame_sel_n, ser_din, power_down_n,
	input logic ser_dout_o, ser_dout_oe, shutdown,
	input logic [63:0] chan_codes,
	input logic [15:0] chan_modes,
	input logic [3:0] avs_address,
	input logic avs_read, avs_write, avs_waitrequest,
	input logic [31:0] avs_writedata, avs_readdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
	sequence s_sel_low; !frame_sel_n [*8]; endsequence
	property p_sd_on; $fell(power_down_n) |-> ##[1:4] shutdown; endproperty
	property p_sd_off; $rose(power_down_n) |-> ##[1:4] !shutdown; endproperty
	property p_od; !ser_dout_o; endproperty
	property p_codes;
		!frame_sel_n && $past(!frame_sel_n, 8) && !$past(avs_write) |-> $stable(chan_codes);
	endproperty
	property p_modes; s_sel_low |-> $stable(chan_modes); endproperty
	property p_ans; s_req |=> !avs_waitrequest; endproperty
	property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
	property p_unmap;
		avs_read && !avs_waitrequest && avs_address > 4'ha |-> avs_readdata == 32'h0;
	endproperty
	property p_hold; frame_sel_n [*8] |-> $stable(ser_dout_oe); endproperty
	a_sd_on: assert property (p_sd_on) else $error("no shutdown");
	a_sd_off: assert property (p_sd_off) else $error("shutdown stuck");
	a_od: assert property (p_od) else $error("drain drives high");
	a_codes: assert property (p_codes) else $error("codes moved in frame");
	a_modes: assert property (p_modes) else $error("modes moved in frame");
	a_ans: assert property (p_ans) else $error("no answer");
	a_one: assert property (p_one) else $error("wait low too long");
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	a_hold: assert property (p_hold) else $error("shift after select");
endmodule // sdip_top_monitor
bind sdip_top sdip_top_monitor u_mon(.*);

// ==== sdip_top_tb.sv ====
module sdip_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, sck, sel_n, din, power_down_n, avs_read, avs_write, dout_o, dout_oe, shutdown;
	logic avs_waitrequest;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [63:0] cc, ec;
	logic [15:0] cm, em;
	int fail_count = 0;
	int cmp_count = 0;
	sdip_host h(.ser_clk(sck), .frame_sel_n(sel_n), .ser_din(din), .dout_wire(dout_oe ? 1'b0 : 1'b1));
	sdip_top dut(.clk(clk), .rst(rst), .ser_clk(sck), .frame_sel_n(sel_n), .ser_din(din),
		.power_down_n(power_down_n), .ser_dout_o(dout_o), .ser_dout_oe(dout_oe),
		.chan_codes(cc), .chan_modes(cm), .shutdown(shutdown), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	task results;
		$display("cmp %0d fail %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [63:0] g, input logic [63:0] e);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
		if (n >= 50) begin
			fail_count++;
			results;
		end
	endtask
	task frame(input logic [15:0] w);
		h.send(w);
		repeat (20) @(posedge clk);
	endtask
	task t_chan;
		for (int i = 0; i < 8; i++) begin
			ec[8*i+:8] = (i == 7) ? 8'hff : 8'h24 * i;
			frame({8'h01 << i, ec[8*i+:8]});
			chk(cc, ec);
		end
		frame(16'hff5a);
		chk(cc, {8{8'h5a}});
		ec = {8{8'h5a}};
		$display("t_chan done");
	endtask
	task t_mode;
		frame(16'h00bb);
		chk(cm, 16'ha0aa);
		frame(16'h00c6);
		chk(cm, 16'h5500);
		chk(cc, ec);
		em = 16'h5500;
		$display("t_mode done");
	endtask
	task t_chain;
		frame(16'h3c96);
		ec[47:16] = {4{8'h96}};
		frame(16'h0000);
		chk(h.got, 16'h3c96);
		chk({cc, cm}, {ec, em});
		$display("t_chain done");
	endtask
	task t_sw;
		av(1, 4'h3, 32'h77);
		ec[31:24] = 8'h77;
		av(0, 4'h3, 0);
		chk(q, 32'h77);
		av(0, 4'hf, 0);
		chk(q, 0);
		av(1, 4'h8, 32'hffff);
		av(0, 4'h8, 0);
		chk({q[15:0], cc}, {em, ec});
		av(0, 4'h9, 0);
		chk(q, 32'h1);
		$display("t_sw done");
	endtask
	task t_pd;
		power_down_n <= 0;
		repeat (8) @(posedge clk);
		chk({shutdown, cc}, {1'b1, ec});
		power_down_n <= 1;
		repeat (8) @(posedge clk);
		chk(shutdown, 0);
		$display("t_pd done");
	endtask
	initial begin
		rst = 1;
		power_down_n = 1;
		avs_read = 0;
		avs_write = 0;
		avs_address = 0;
		avs_writedata = 0;
		ec = 0;
		em = 0;
		repeat (4) @(posedge clk);
		rst <= 0;
		repeat (4) @(posedge clk);
		t_chan;
		t_mode;
		t_chain;
		t_sw;
		t_pd;
		results;
	end
endmodule // sdip_top_tb
